// file: verilog/servo_cmd_interp.sv
// apb command interpreter for servo write and status read commands
//
// Overview of operation
// - every command gets a reply or error
// - alarm history erase with key
// - current alarm clear with key
// - prohibit inputs except stop and limits
// - disable all outputs with key
// - release input prohibition with key
// - release output prohibition with key
// - select test mode zero to four
// - set test operation input signals
// - set communication input device signals
// - force signal output pins in test mode four
// - test speed up to 7fff
// - acceleration time constant, eight characters
// - moving distance, eight characters
// - positioning direction zero or one
// - start positioning with key
// - stop, go, clear remaining distance
// - type zero: receiver converts, places point
// - type one: receiver uses data unchanged
// - decimal needs point position, hex zero
// - return status item name and unit
// - return status item value and info
// - select parameter group zero to three
// - clear cumulative feedback pulse with key
`timescale 1ns/10ps
`default_nettype none
module servo_cmd_interp
  import servo_cmd_pkg::*;
#(
  parameter int IN_W  = 16,
  parameter int OUT_W = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // apb slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  output logic      [31:0]      o_prdata,
  // device pins and servo logic
  input  wire logic [IN_W-1:0]  i_input_pins,
  input  wire logic [OUT_W-1:0] i_output_devices,
  input  wire logic [31:0]      i_status_value,
  input  wire logic [4:0]       i_status_info,
  output logic      [IN_W-1:0]  o_input_devices,
  output logic      [OUT_W-1:0] o_output_pins,
  output logic                  o_analog_enable,
  output logic                  o_pulse_enable,
  output logic      [3:0]       o_status_sel,
  // events to the servo core
  output logic                  o_alarm_clear,
  output logic                  o_history_erase,
  output logic                  o_feedback_clear,
  output logic                  o_pos_start,
  output logic                  o_remaining_distance_clear,
  output logic                  o_param_write,
  output logic      [7:0]       o_param_no,
  output logic      [31:0]      o_param_value,
  // test operation settings
  output logic      [2:0]       o_test_mode,
  output logic      [1:0]       o_param_group,
  output logic      [31:0]      o_test_inputs,
  output logic      [31:0]      o_comm_inputs,
  output logic      [31:0]      o_forced_outputs,
  output logic      [15:0]      o_test_speed,
  output logic      [31:0]      o_accel_time,
  output logic      [31:0]      o_move_distance,
  output logic                  o_direction,
  output logic                  o_pos_paused
);
  // reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end
  // pin synchroniser
  logic [IN_W-1:0] pin_meta_q;
  logic [IN_W-1:0] pin_q;
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= '0;
      pin_q      <= '0;
    end else begin
      pin_meta_q <= i_input_pins;
      pin_q      <= pin_meta_q;
    end
  end
  // apb decode
  cmd_type     cmd_q;
  logic [31:0] data_q;
  logic [31:0] reply_q;
  info_type    info_q;
  status_type  stat;
  state_type   state_q;
  state_type   state_d;
  logic        err_q;
  logic        done_q;
  logic        in_block_q;
  logic        out_block_q;
  wire         acc        = i_psel & i_penable;
  wire         commit     = acc & o_pready;
  wire         sel_cmd    = i_paddr == ADDR_CMD;
  wire         sel_data   = i_paddr == ADDR_DATA;
  wire         sel_status = i_paddr == ADDR_STATUS;
  wire         sel_reply  = i_paddr == ADDR_REPLY;
  wire         sel_info   = i_paddr == ADDR_INFO;
  wire         sel_state  = i_paddr == ADDR_STATE;
  wire         mapped     = sel_cmd | sel_data | sel_status | sel_reply | sel_info | sel_state;
  wire         busy       = state_q != ST_IDLE;
  wire         wr_cmd     = commit & i_pwrite & sel_cmd & ~busy;
  wire         wr_data    = commit & i_pwrite & sel_data & ~busy;
  wire cmd_type wcmd      = i_pwdata;
  wire         launch     = wr_cmd & wcmd.go;
  wire         bus_err    = ~mapped | (i_pwrite & (sel_cmd | sel_data) & busy)
                            | (i_pwrite & (sel_status | sel_reply | sel_info | sel_state));
  assign stat = '{rsvd: '0, err: err_q, done: done_q, busy: busy};
  wire [31:0]  state_word = {24'h0, in_block_q, out_block_q, 1'b0, o_param_group, o_test_mode};
  wire [31:0]  rd_mux = sel_cmd ? cmd_q : sel_data ? data_q : sel_status ? stat :
                        sel_reply ? reply_q : sel_info ? {27'h0, info_q} :
                        sel_state ? state_word : RST_WORD;
  // apb answer with one wait state
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= RST_WORD;
    end else begin
      o_pready  <= acc & ~o_pready;
      o_pslverr <= acc & ~o_pready & bus_err;
      o_prdata  <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : RST_WORD;
    end
  end
  // command and data registers
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q  <= '0;
      data_q <= RST_WORD;
    end else begin
      if (wr_cmd) cmd_q <= wcmd;
      if (wr_data) data_q <= i_pwdata;
    end
  end
  // command decode
  wire [7:0] c     = cmd_q.code;
  wire [7:0] n     = cmd_q.data_no;
  wire       l8    = cmd_q.len8;
  wire       l4    = ~cmd_q.len8;
  wire       key   = data_q == KEY_VALUE;
  wire [3:0] dp    = data_q[PW_DP_HI:PW_DP_LO];
  wire hit_hist    = c == CMD_ALARM & n == DN_20;
  wire hit_alarm   = c == CMD_ALARM & n == DN_00;
  wire hit_in_off  = c == CMD_PROHIBIT & n == DN_00;
  wire hit_out_off = c == CMD_PROHIBIT & n == DN_03;
  wire hit_in_on   = c == CMD_PROHIBIT & n == DN_10;
  wire hit_out_on  = c == CMD_PROHIBIT & n == DN_13;
  wire hit_mode    = c == CMD_MODE & n == DN_00;
  wire hit_tin     = c == CMD_EXT_IO & n == DN_00;
  wire hit_comm    = c == CMD_EXT_IO & n == DN_60;
  wire hit_force   = c == CMD_EXT_IO & n == DN_A0;
  wire hit_speed   = c == CMD_TEST & n == DN_10;
  wire hit_accel   = c == CMD_TEST & n == DN_11;
  wire hit_dist    = c == CMD_TEST & n == DN_20;
  wire hit_dir     = c == CMD_TEST & n == DN_21;
  wire hit_start   = c == CMD_TEST & n == DN_40;
  wire hit_pause   = c == CMD_TEST & n == DN_41;
  wire hit_group   = c == CMD_GROUP & n == DN_00;
  wire hit_fb      = c == CMD_FB_CLEAR & n == DN_00;
  wire hit_param   = c == CMD_PARAM_WR & n != DN_00;
  wire hit_name    = c == CMD_STATUS_RD & n <= DN_NAME_LAST;
  wire hit_value   = c == CMD_STATUS_RD & n >= DN_VALUE_BASE & n <= DN_VALUE_LAST;
  wire is_stop     = data_q == ASCII_STOP;
  wire is_go       = data_q == ASCII_GO;
  wire is_clear    = data_q == ASCII_CLEAR;
  wire dp_ok       = cmd_q.decimal ? (dp != 4'h0 & dp <= DP_MAX) : dp == 4'h0;
  wire ok_hist     = hit_hist & l4 & key;
  wire ok_alarm    = hit_alarm & l4 & key;
  wire ok_in_off   = hit_in_off & l4;
  wire ok_out_off  = hit_out_off & l4 & key;
  wire ok_in_on    = hit_in_on & l4 & key;
  wire ok_out_on   = hit_out_on & l4 & key;
  wire ok_mode     = hit_mode & l4 & data_q <= MODE_MAX;
  wire ok_tin      = hit_tin & l8;
  wire ok_comm     = hit_comm & l8;
  wire ok_force    = hit_force & l8;
  wire ok_speed    = hit_speed & l4 & data_q <= SPEED_MAX;
  wire ok_accel    = hit_accel & l8 & data_q <= LONG_MAX;
  wire ok_dist     = hit_dist & l8 & data_q <= LONG_MAX;
  wire ok_dir      = hit_dir & l4 & data_q <= DIR_MAX;
  wire ok_start    = hit_start & l4 & key;
  wire ok_pause    = hit_pause & l4 & (is_stop | is_go | is_clear);
  wire ok_group    = hit_group & l4 & data_q <= GROUP_MAX;
  wire ok_fb       = hit_fb & l4 & key;
  wire ok_param    = hit_param & l8 & dp_ok;
  wire ok_read     = hit_name | hit_value;
  // any other command gets an error reply
  wire cmd_ok      = ok_hist | ok_alarm | ok_in_off | ok_out_off | ok_in_on | ok_out_on
                     | ok_mode | ok_tin | ok_comm | ok_force | ok_speed | ok_accel
                     | ok_dist | ok_dir | ok_start | ok_pause | ok_group | ok_fb
                     | ok_param | ok_read;
  wire exec        = state_q == ST_EXEC;
  wire apply       = exec & cmd_ok;
  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (launch) state_d = ST_EXEC;
      ST_EXEC:  state_d = (cmd_ok & ok_read) ? ST_FETCH : ST_IDLE;
      ST_FETCH: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (launch) begin
        err_q  <= 1'b0;
        done_q <= 1'b0;
      end else if (exec & ~(cmd_ok & ok_read)) begin
        err_q  <= ~cmd_ok;
        done_q <= 1'b1;
      end else if (state_q == ST_FETCH) begin
        done_q <= 1'b1;
      end
    end
  end
  // status name lookup
  logic [31:0] name_code;
  status_name_rom u_name_rom (
    .i_clk  (i_clk),
    .i_addr (n[3:0]),
    .o_data (name_code)
  );
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reply_q      <= RST_WORD;
      info_q       <= '0;
      o_status_sel <= 4'h0;
    end else begin
      o_status_sel <= n[3:0];
      if (state_q == ST_FETCH) begin
        reply_q <= hit_value ? i_status_value : name_code;
        info_q  <= hit_value ? i_status_info : '0;
      end
    end
  end
  // one-cycle events
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_alarm_clear              <= 1'b0;
      o_history_erase            <= 1'b0;
      o_feedback_clear           <= 1'b0;
      o_pos_start                <= 1'b0;
      o_remaining_distance_clear <= 1'b0;
      o_param_write              <= 1'b0;
    end else begin
      o_alarm_clear              <= apply & ok_alarm;
      o_history_erase            <= apply & ok_hist;
      o_feedback_clear           <= apply & ok_fb;
      o_pos_start                <= apply & ok_start;
      o_remaining_distance_clear <= apply & ok_pause & is_clear;
      o_param_write              <= apply & ok_param;
    end
  end
  // stored settings
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_block_q       <= 1'b0;
      out_block_q      <= 1'b0;
      o_test_mode      <= MODE_NORMAL;
      o_param_group    <= 2'h0;
      o_test_inputs    <= RST_WORD;
      o_comm_inputs    <= RST_WORD;
      o_forced_outputs <= RST_WORD;
      o_test_speed     <= 16'h0000;
      o_accel_time     <= RST_WORD;
      o_move_distance  <= RST_WORD;
      o_direction      <= 1'b0;
      o_pos_paused     <= 1'b0;
      o_param_no       <= 8'h00;
      o_param_value    <= RST_WORD;
    end else if (apply) begin
      if (ok_in_off | ok_in_on) in_block_q <= ok_in_off;
      if (ok_out_off | ok_out_on) out_block_q <= ok_out_off;
      if (ok_mode) o_test_mode <= data_q[2:0];
      if (ok_group) o_param_group <= data_q[1:0];
      if (ok_tin) o_test_inputs <= data_q;
      if (ok_comm) o_comm_inputs <= data_q;
      if (ok_force) o_forced_outputs <= data_q;
      if (ok_speed) o_test_speed <= data_q[15:0];
      if (ok_accel) o_accel_time <= data_q;
      if (ok_dist) o_move_distance <= data_q;
      if (ok_dir) o_direction <= data_q[0];
      if (ok_pause & is_stop) o_pos_paused <= 1'b1;
      if ((ok_pause & (is_go | is_clear)) | ok_start) o_pos_paused <= 1'b0;
      if (ok_param) o_param_no <= n;
      if (ok_param) o_param_value <= data_q;
    end
  end
  // gated inputs, exempt stop and limits
  wire [IN_W-1:0]  exempt    = (IN_W'(1) << ESTOP_BIT) | (IN_W'(1) << FWD_LIMIT_BIT)
                               | (IN_W'(1) << REV_LIMIT_BIT);
  wire [IN_W-1:0]  in_gated  = in_block_q ? (pin_q & exempt) : pin_q;
  wire             forced    = o_test_mode == MODE_FORCED;
  wire [OUT_W-1:0] out_src   = forced ? o_forced_outputs[OUT_W-1:0] : i_output_devices;
  wire [OUT_W-1:0] out_gated = out_block_q ? '0 : out_src;
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_input_devices <= '0;
      o_output_pins   <= '0;
      o_analog_enable <= 1'b0;
      o_pulse_enable  <= 1'b0;
    end else begin
      o_input_devices <= in_gated;
      o_output_pins   <= out_gated;
      o_analog_enable <= ~in_block_q;
      o_pulse_enable  <= ~in_block_q;
    end
  end
endmodule
`default_nettype wire

// file: verilog/servo_cmd_pkg.sv
// constants, layouts and types for the servo command interpreter
package servo_cmd_pkg;
  // apb byte offsets
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_DATA   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_REPLY  = 8'h0c;
  localparam logic [7:0] ADDR_INFO   = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;
  // command codes
  localparam logic [7:0] CMD_STATUS_RD = 8'h01;
  localparam logic [7:0] CMD_FB_CLEAR  = 8'h81;
  localparam logic [7:0] CMD_ALARM     = 8'h82;
  localparam logic [7:0] CMD_PARAM_WR  = 8'h84;
  localparam logic [7:0] CMD_GROUP     = 8'h85;
  localparam logic [7:0] CMD_MODE      = 8'h8b;
  localparam logic [7:0] CMD_PROHIBIT  = 8'h90;
  localparam logic [7:0] CMD_EXT_IO    = 8'h92;
  localparam logic [7:0] CMD_TEST      = 8'ha0;
  // data numbers
  localparam logic [7:0] DN_00 = 8'h00;
  localparam logic [7:0] DN_03 = 8'h03;
  localparam logic [7:0] DN_10 = 8'h10;
  localparam logic [7:0] DN_11 = 8'h11;
  localparam logic [7:0] DN_13 = 8'h13;
  localparam logic [7:0] DN_20 = 8'h20;
  localparam logic [7:0] DN_21 = 8'h21;
  localparam logic [7:0] DN_40 = 8'h40;
  localparam logic [7:0] DN_41 = 8'h41;
  localparam logic [7:0] DN_60 = 8'h60;
  localparam logic [7:0] DN_A0 = 8'ha0;
  localparam logic [7:0] DN_NAME_LAST  = 8'h0e;
  localparam logic [7:0] DN_VALUE_BASE = 8'h80;
  localparam logic [7:0] DN_VALUE_LAST = 8'h8e;
  // data values and ranges
  localparam logic [31:0] KEY_VALUE    = 32'h0000_1ea5;
  localparam logic [31:0] MODE_MAX     = 32'h0000_0004;
  localparam logic [31:0] GROUP_MAX    = 32'h0000_0003;
  localparam logic [31:0] SPEED_MAX    = 32'h0000_7fff;
  localparam logic [31:0] LONG_MAX     = 32'h07ff_ffff;
  localparam logic [31:0] DIR_MAX      = 32'h0000_0001;
  localparam logic [31:0] ASCII_STOP   = 32'h5354_4f50;
  localparam logic [31:0] ASCII_GO     = 32'h474f_2020;
  localparam logic [31:0] ASCII_CLEAR  = 32'h434c_5220;
  // test modes
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_FORCED  = 3'h4;
  // parameter write data layout: dp position in the top character
  localparam int PW_DP_HI  = 31;
  localparam int PW_DP_LO  = 28;
  localparam logic [3:0] DP_MAX = 4'h5;
  // exempt input bits
  localparam int ESTOP_BIT = 0;
  localparam int FWD_LIMIT_BIT = 1;
  localparam int REV_LIMIT_BIT = 2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // command word layout
  typedef struct packed {
    logic       go;
    logic [12:0] rsvd;
    logic       decimal;
    logic       len8;
    logic [7:0] data_no;
    logic [7:0] code;
  } cmd_type;
  // status word layout
  typedef struct packed {
    logic [28:0] rsvd;
    logic        err;
    logic        done;
    logic        busy;
  } status_type;
  // processing information of a status value
  typedef struct packed {
    logic       disp_type;
    logic [3:0] dp_pos;
  } info_type;
  // interpreter states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FETCH = 2'b11
  } state_type;
endpackage

// file: verilog/status_name_rom.sv
// name and unit codes of the status display items, registered read
`timescale 1ns/10ps
`default_nettype none
module status_name_rom (
  // clock
  input  wire logic        i_clk,
  // lookup
  input  wire logic [3:0]  i_addr,
  output logic      [31:0] o_data
);
  logic [31:0] rom_d;
  // codes are arbitrary four-character tags
  always_comb begin
    unique case (i_addr)
      4'h0:    rom_d = 32'h4642_5020;
      4'h1:    rom_d = 32'h5350_4420;
      4'h2:    rom_d = 32'h4452_5020;
      4'h3:    rom_d = 32'h434d_5020;
      4'h4:    rom_d = 32'h4346_5120;
      4'h5:    rom_d = 32'h4153_5620;
      4'h6:    rom_d = 32'h4154_5620;
      4'h7:    rom_d = 32'h5247_4e20;
      4'h8:    rom_d = 32'h4546_4620;
      4'h9:    rom_d = 32'h504b_4c20;
      4'ha:    rom_d = 32'h5451_4920;
      4'hb:    rom_d = 32'h4f4e_4520;
      4'hc:    rom_d = 32'h4142_5320;
      4'hd:    rom_d = 32'h494e_5220;
      4'he:    rom_d = 32'h4255_5320;
      default: rom_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk) begin
    o_data <= rom_d;
  end
endmodule
`default_nettype wire

// file: verif/servo_cmd_props.sv
// port assertions for the servo command interpreter
`timescale 1ns/10ps
`default_nettype none
module servo_cmd_props
  import servo_cmd_pkg::*;
#(
  parameter int IN_W = 16
) (
  // clock, reset and apb
  input wire logic            i_clk,
  input wire logic            i_rst_n,
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic            o_pready,
  input wire logic            o_pslverr,
  // servo side
  input wire logic [IN_W-1:0] o_input_devices,
  input wire logic            o_analog_enable,
  input wire logic            o_alarm_clear,
  input wire logic            o_history_erase,
  input wire logic            o_pos_start,
  input wire logic            o_param_write,
  input wire logic [31:0]     o_param_value,
  input wire logic [2:0]      o_test_mode,
  input wire logic [15:0]     o_test_speed,
  input wire logic [31:0]     o_accel_time,
  input wire logic            o_pos_paused
);
  logic [3:0] age_q;
  logic [3:0] age_d;
  wire logic  wr_done;
  assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
  assign age_d = wr_done ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) age_q <= 4'hf;
    else age_q <= age_d;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ready_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  event_age_a: assert property ((o_alarm_clear || o_history_erase) |-> age_q inside {[1:3]})
    else $error("alarm event without write");
  mode_range_a: assert property (o_test_mode <= 3'h4)
    else $error("mode out of range");
  speed_range_a: assert property (o_test_speed <= 16'h7fff)
    else $error("speed out of range");
  accel_range_a: assert property (o_accel_time <= LONG_MAX)
    else $error("accel out of range");
  start_unpause_a: assert property (o_pos_start |-> !o_pos_paused)
    else $error("start left paused");
  dp_range_a: assert property (o_param_write |-> o_param_value[31:28] <= DP_MAX)
    else $error("bad point position");
  inputs_masked_a: assert property ((!o_analog_enable && !$past(o_analog_enable))
    |-> o_input_devices[IN_W-1:3] == '0)
    else $error("inputs not blocked");
  cover property (o_pos_start);
  cover property (o_pslverr);
  cover property (o_param_write);
endmodule
bind servo_cmd_interp servo_cmd_props #(.IN_W(IN_W)) servo_cmd_props_i (.*);
`default_nettype wire

// file: verif/servo_core_model.sv
// behavioural servo core feeding status values and outputs
`timescale 1ns/10ps
`default_nettype none
module servo_core_model #(
  parameter logic [15:0] OUT_PAT = 16'ha5c3
) (
  // selection
  input  wire logic [3:0]  i_sel,
  // values
  output logic      [31:0] o_value,
  output logic      [4:0]  o_info,
  output logic      [15:0] o_outputs
);
  assign o_value = {28'h1234567, i_sel};
  assign o_info = {i_sel[0], i_sel};
  assign o_outputs = OUT_PAT;
endmodule
`default_nettype wire

// file: verif/servo_cmd_interp_tb.sv
// self-checking bench for the servo command interpreter
`timescale 1ns/10ps
`default_nettype none
`define C(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value %s expected %0h seen %0h", n, e, g); \
    end \
  end
module servo_cmd_interp_tb;
  import servo_cmd_pkg::*;
  localparam logic [15:0] P = 16'ha5c3;
  localparam logic [31:0] K = KEY_VALUE;
  localparam logic N = 1'b0;
  localparam logic Y = 1'b1;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic [15:0] i_input_pins = 16'hffff;
  logic er;
  int checked = 0, bad_count = 0, cyc = 0, evc[6] = '{default: 0};
  wire logic o_pready, o_pslverr, o_analog_enable, o_pulse_enable, o_alarm_clear;
  wire logic o_history_erase, o_feedback_clear, o_pos_start, o_remaining_distance_clear;
  wire logic o_param_write, o_direction, o_pos_paused;
  wire logic [31:0] o_prdata, o_param_value, o_test_inputs, o_comm_inputs, o_forced_outputs;
  wire logic [31:0] o_accel_time, o_move_distance, i_status_value;
  wire logic [15:0] o_input_devices, o_output_pins, o_test_speed, i_output_devices;
  wire logic [7:0] o_param_no;
  wire logic [4:0] i_status_info;
  wire logic [3:0] o_status_sel;
  wire logic [2:0] o_test_mode;
  wire logic [1:0] o_param_group;
  wire logic [5:0] ev;
  assign ev = {o_param_write, o_remaining_distance_clear, o_pos_start,
               o_feedback_clear, o_history_erase, o_alarm_clear};
  servo_cmd_interp servo_cmd_interp_i (.*);
  servo_core_model #(.OUT_PAT(P)) servo_core_model_i (.i_sel(o_status_sel),
    .o_value(i_status_value), .o_info(i_status_info), .o_outputs(i_output_devices));
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    foreach (evc[k]) if (ev[k] === 1'b1) evc[k]++;
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task cmd(input logic [7:0] c, n, input logic l8, dc, input logic [31:0] d, input logic xe);
    apb(Y, ADDR_DATA, d);
    apb(Y, ADDR_CMD, {1'b1, 13'h0, dc, l8, n, c});
    `C("cmd taken", N, er)
    do apb(N, ADDR_STATUS, 32'h0);
    while (rd[1] !== 1'b1);
    `C("status err", xe, rd[2])
  endtask
  task t_regs;
    apb(N, 8'h18, 32'h0);
    `C("unmapped", Y, er)
    apb(Y, ADDR_STATUS, 32'h5);
    `C("read only", Y, er)
    apb(N, ADDR_STATE, 32'h0);
    `C("state", 32'h0, rd)
  endtask
  task t_alarm;
    cmd(CMD_ALARM, DN_20, N, N, K, N);
    `C("history", 1, evc[1])
    cmd(CMD_ALARM, DN_00, N, N, 32'h1234, Y);
    cmd(CMD_ALARM, DN_00, N, N, K, N);
    `C("alarm", 1, evc[0])
    cmd(CMD_FB_CLEAR, DN_00, N, N, K, N);
    `C("feedback", 1, evc[2])
  endtask
  task t_io;
    cmd(CMD_PROHIBIT, DN_00, N, N, 32'h0, N);
    `C("inputs off", 16'h0007, o_input_devices)
    `C("analog off", 2'b00, {o_analog_enable, o_pulse_enable})
    cmd(CMD_PROHIBIT, DN_03, N, N, K, N);
    `C("outs off", 16'h0, o_output_pins)
    i_input_pins <= 16'h5a5a;
    repeat (4) @(posedge i_clk);
    `C("inputs held", 16'h0002, o_input_devices)
    cmd(CMD_PROHIBIT, DN_10, N, N, K, N);
    `C("inputs on", 16'h5a5a, o_input_devices)
    cmd(CMD_PROHIBIT, DN_13, N, N, K, N);
    `C("outs on", P, o_output_pins)
  endtask
  task t_mode;
    for (int m = 0; m < 6; m++) begin
      cmd(CMD_MODE, DN_00, N, N, 32'(m), m > 4);
      `C("mode", (m > 4) ? 3'h4 : 3'(m), o_test_mode)
    end
    cmd(CMD_EXT_IO, DN_A0, Y, N, 32'h3c3c, N);
    `C("forced", 16'h3c3c, o_output_pins)
    `C("forced reg", 32'h3c3c, o_forced_outputs)
    cmd(CMD_EXT_IO, DN_00, Y, N, 32'h11, N);
    `C("test in", 32'h11, o_test_inputs)
    cmd(CMD_EXT_IO, DN_60, N, N, 32'h22, Y);
    cmd(CMD_EXT_IO, DN_60, Y, N, 32'h22, N);
    `C("comm in", 32'h22, o_comm_inputs)
    cmd(CMD_MODE, DN_00, N, N, 32'h2, N);
    `C("pins back", P, o_output_pins)
  endtask
  task t_test;
    cmd(CMD_TEST, DN_10, N, N, SPEED_MAX, N);
    cmd(CMD_TEST, DN_10, N, N, 32'h8000, Y);
    `C("speed", 16'h7fff, o_test_speed)
    cmd(CMD_TEST, DN_11, Y, N, LONG_MAX, N);
    `C("accel", LONG_MAX, o_accel_time)
    cmd(CMD_TEST, DN_20, Y, N, 32'h5, N);
    cmd(CMD_TEST, DN_20, Y, N, 32'h0800_0000, Y);
    `C("distance", 32'h5, o_move_distance)
    cmd(CMD_TEST, DN_21, N, N, 32'h1, N);
    cmd(CMD_TEST, DN_21, N, N, 32'h2, Y);
    `C("direction", Y, o_direction)
    cmd(CMD_TEST, DN_40, N, N, K, N);
    `C("start", 1, evc[3])
    cmd(CMD_TEST, DN_41, N, N, ASCII_STOP, N);
    `C("paused", Y, o_pos_paused)
    cmd(CMD_TEST, DN_41, N, N, ASCII_GO, N);
    `C("resumed", N, o_pos_paused)
    cmd(CMD_TEST, DN_41, N, N, ASCII_CLEAR, N);
    `C("clear", 1, evc[4])
  endtask
  task t_stat;
    cmd(CMD_STATUS_RD, 8'h03, N, N, 32'h0, N);
    apb(N, ADDR_INFO, 32'h0);
    `C("name info", 32'h0, rd)
    cmd(CMD_STATUS_RD, 8'h85, N, N, 32'h0, N);
    apb(N, ADDR_REPLY, 32'h0);
    `C("value", 32'h1234_5675, rd)
    `C("status sel", 4'h5, o_status_sel)
    apb(N, ADDR_INFO, 32'h0);
    `C("info", 32'h15, rd)
  endtask
  task t_param;
    cmd(CMD_GROUP, DN_00, N, N, GROUP_MAX, N);
    cmd(CMD_GROUP, DN_00, N, N, 32'h4, Y);
    `C("group", 2'h3, o_param_group)
    cmd(CMD_PARAM_WR, 8'h0c, Y, Y, 32'h2000_009b, N);
    `C("param no", 8'h0c, o_param_no)
    `C("param val", 32'h2000_009b, o_param_value)
    cmd(CMD_PARAM_WR, 8'h0c, Y, Y, 32'h0000_009b, Y);
    cmd(CMD_PARAM_WR, 8'h0c, Y, N, 32'h3000_009b, Y);
    cmd(CMD_PARAM_WR, 8'h0d, Y, N, 32'h0000_3abc, N);
    `C("writes", 2, evc[5])
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    t_regs();
    t_alarm();
    t_io();
    t_mode();
    t_test();
    t_stat();
    t_param();
    finish_test();
  end
endmodule
`default_nettype wire
